// >>> logic/tip_host_end.sv
// translation agent end: APB-controlled invalidation sender and response counter
`timescale 1ns/1ps
`default_nettype none
module tip_host_end import tip_pkg::*; (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  tip_link_if.host_end LINK,
  output logic INV_BUSY,
  output logic INV_DONE
);

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_SEND = 3'b010,
    HS_WAIT = 3'b100
  } tip_hs_type;

  tip_hs_type st_r, st_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pass_r, pass_nxt;
  logic [4:0] tag_r, tag_nxt;
  logic size_r, size_nxt;
  logic [51:0] va_r, va_nxt;
  logic [15:0] tgt_r, tgt_nxt;
  logic [15:0] own_r, own_nxt;
  logic [4:0] unit_r, unit_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic err_r, err_nxt;
  logic [3:0] got_r, got_nxt;
  logic [3:0] total_r, total_nxt;
  logic [31:0] seen_r, seen_nxt;
  logic [4:0] beat_r, beat_nxt;
  logic qv_r, qv_nxt;
  logic qc_r, qc_nxt;
  logic [7:0] qd_r, qd_nxt;
  logic [3:0] rx_idx_r, rx_idx_nxt;
  logic rx_ok_r, rx_ok_nxt;
  logic [2:0] rx_cc_r, rx_cc_nxt;
  logic [31:0] rx_mask_r, rx_mask_nxt;

  logic wr_en;
  logic mapped;
  logic go;
  assign wr_en = PSEL && PENABLE && pready_r && PWRITE;
  assign mapped = (PADDR[1:0] == 2'h0) && (PADDR <= OFS_REGION);
  // a start while busy is dropped silently
  assign go = wr_en && (PADDR == OFS_CTRL) && PWDATA[CTRL_GO] && (st_r == HS_IDLE);

  // no wait states: ready in the first access cycle
  always_comb begin
    pready_nxt = PSEL && !PENABLE;
    pslverr_nxt = PSEL && !PENABLE && !mapped;
    prdata_nxt = REG_RST;
    if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        OFS_CTRL: prdata_nxt = {30'h0, pass_r, busy_r};
        OFS_TAGSZ: prdata_nxt = {23'h0, size_r, 3'h0, tag_r};
        OFS_VALO: prdata_nxt = {va_r[19:0], 12'h000};
        OFS_VAHI: prdata_nxt = va_r[51:20];
        OFS_TGT: prdata_nxt = {16'h0000, tgt_r};
        OFS_OWN: prdata_nxt = {11'h000, unit_r, own_r};
        OFS_STAT: prdata_nxt = {16'h0000, total_r, got_r, 5'h00, err_r, done_r, busy_r};
        OFS_SEEN: prdata_nxt = seen_r;
        OFS_REGION: prdata_nxt = {25'h0, region_shift(size_r, va_r)}; // R9
        default: prdata_nxt = REG_RST;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= REG_RST;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // parameters frozen while a request is outstanding
  always_comb begin
    pass_nxt = pass_r;
    tag_nxt = tag_r;
    size_nxt = size_r;
    va_nxt = va_r;
    tgt_nxt = tgt_r;
    own_nxt = own_r;
    unit_nxt = unit_r;
    if (wr_en && st_r == HS_IDLE) begin
      case (PADDR)
        OFS_CTRL: pass_nxt = PWDATA[CTRL_PASS];
        OFS_TAGSZ: begin
          tag_nxt = PWDATA[4:0];
          size_nxt = PWDATA[TAGSZ_SIZE];
        end
        OFS_VALO: va_nxt[19:0] = PWDATA[31:12];
        OFS_VAHI: va_nxt[51:20] = PWDATA;
        OFS_TGT: tgt_nxt = PWDATA[15:0];
        OFS_OWN: begin
          own_nxt = PWDATA[15:0];
          unit_nxt = PWDATA[20:16];
        end
        default: pass_nxt = pass_r;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pass_r <= 1'b0;
      tag_r <= 5'h00;
      size_r <= 1'b0;
      va_r <= 52'h0;
      tgt_r <= 16'h0000;
      own_r <= 16'h0000;
      unit_r <= 5'h00;
    end else begin
      pass_r <= pass_nxt;
      tag_r <= tag_nxt;
      size_r <= size_nxt;
      va_r <= va_nxt;
      tgt_r <= tgt_nxt;
      own_r <= own_nxt;
      unit_r <= unit_nxt;
    end
  end

  always_comb begin
    int k;
    logic set_done;
    logic set_err;
    logic clr_st;
    logic [3:0] tot;
    k = int'(rx_idx_r);
    set_done = 1'b0;
    set_err = 1'b0;
    clr_st = wr_en && (PADDR == OFS_STAT);
    tot = total_r;
    st_nxt = st_r;
    busy_nxt = busy_r;
    got_nxt = got_r;
    total_nxt = total_r;
    seen_nxt = seen_r;
    beat_nxt = beat_r;
    qv_nxt = 1'b0;
    qc_nxt = 1'b0;
    qd_nxt = 8'h00;
    rx_idx_nxt = rx_idx_r;
    rx_ok_nxt = rx_ok_r;
    rx_cc_nxt = rx_cc_r;
    rx_mask_nxt = rx_mask_r;
    if (LINK.rsp_valid && (rx_idx_r != 4'h0 || LINK.rsp_ctl)) begin
      rx_ok_nxt = ((rx_idx_r == 4'h0) | rx_ok_r) & (LINK.rsp_ctl == (k < CTL_BEATS))
                  & hdr_ok({1'b0, rx_idx_r}, LINK.rsp_data, 1'b1); // R2
      if (rx_idx_r == 4'h7) begin
        rx_cc_nxt = LINK.rsp_data[CC_LSB +: 3];
      end
      if (k >= CTL_BEATS) begin
        rx_mask_nxt[8 * (k - CTL_BEATS) +: 8] = LINK.rsp_data; // R6
      end
      rx_idx_nxt = rx_idx_r + 4'h1;
      if (k == RSP_BEATS - 1) begin
        rx_idx_nxt = 4'h0;
        if (!rx_ok_nxt) begin
          set_err = 1'b1;
        end else if (st_r == HS_WAIT && rx_mask_nxt[tag_r]) begin
          // first response fixes the total; later ones must agree
          if (got_r == 4'h0) begin
            tot = cc_decode(rx_cc_nxt); // R8
          end else if (cc_decode(rx_cc_nxt) != total_r) begin
            set_err = 1'b1;
          end
          total_nxt = tot;
          got_nxt = got_r + 4'h1;
          seen_nxt = seen_r | rx_mask_nxt;
          if (got_r + 4'h1 == tot) begin
            set_done = 1'b1; // R10
            busy_nxt = 1'b0;
            st_nxt = HS_IDLE;
          end
        end
      end
    end
    case (st_r)
      HS_IDLE: begin
        if (go) begin
          st_nxt = HS_SEND; // R1
          busy_nxt = 1'b1;
          beat_nxt = 5'h00;
          got_nxt = 4'h0;
          total_nxt = 4'h0;
          seen_nxt = 32'h0000_0000;
        end
      end
      HS_SEND: begin
        qv_nxt = 1'b1;
        qc_nxt = (int'(beat_r) < CTL_BEATS);
        case (beat_r)
          5'h0C: qd_nxt = {tag_r, 3'h0}; // R4
          5'h0D: qd_nxt = {va_r[3:0], size_r, 3'h0}; // R4
          default: begin
            if (int'(beat_r) < CTL_BEATS) begin
              qd_nxt = hdr_byte(beat_r, own_r, unit_r, tgt_r, pass_r, 1'b0, 3'h0); // R3
            end else begin
              qd_nxt = va_r[8 * (int'(beat_r) - 14) + 4 +: 8]; // R4
            end
          end
        endcase
        if (int'(beat_r) == REQ_BEATS - 1) begin
          st_nxt = HS_WAIT;
        end else begin
          beat_nxt = beat_r + 5'h01;
        end
      end
      HS_WAIT: st_nxt = st_nxt;
      default: st_nxt = HS_IDLE;
    endcase
    // hardware set beats software clear; a start clears done
    done_nxt = (done_r && !(clr_st && PWDATA[ST_DONE]) && !go) || set_done;
    err_nxt = (err_r && !(clr_st && PWDATA[ST_ERR])) || set_err;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_r <= HS_IDLE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      got_r <= 4'h0;
      total_r <= 4'h0;
      seen_r <= 32'h0000_0000;
      beat_r <= 5'h00;
      qv_r <= 1'b0;
      qc_r <= 1'b0;
      qd_r <= 8'h00;
      rx_idx_r <= 4'h0;
      rx_ok_r <= 1'b0;
      rx_cc_r <= 3'h0;
      rx_mask_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      got_r <= got_nxt;
      total_r <= total_nxt;
      seen_r <= seen_nxt;
      beat_r <= beat_nxt;
      qv_r <= qv_nxt;
      qc_r <= qc_nxt;
      qd_r <= qd_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_ok_r <= rx_ok_nxt;
      rx_cc_r <= rx_cc_nxt;
      rx_mask_r <= rx_mask_nxt;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign LINK.req_valid = qv_r;
  assign LINK.req_ctl = qc_r;
  assign LINK.req_data = qd_r;
  assign INV_BUSY = busy_r;
  assign INV_DONE = done_r;

endmodule : tip_host_end
`default_nettype wire

// >>> logic/tip_pkg.sv
// shared constants, packet layouts and helpers for translation invalidation packets
// Operation
// R1 - agent may send invalidation; device decodes it
// R2 - both posted writes; response flag separates them
// R3 - prefix, posted write, fixed window, target
// R4 - request count 01b; tag, size, address payload
// R5 - response: same header, pass 0, count 00b
// R6 - response payload is 32-bit tag mask
// R7 - one response per channel; total announced
// R8 - reply total 000b means eight, else direct
// R9 - size bit: 4KB or lowest zero bit
// R10 - agent finishes after announced responses arrive
package tip_pkg;

  localparam int CTL_BEATS = 12;
  localparam int REQ_BEATS = 20;
  localparam int RSP_BEATS = 16;
  localparam int PAGE_SHIFT = 12;
  localparam int MAX_RESP = 8;

  localparam logic [7:0] PFX_B0 = 8'hBE;
  localparam logic [7:0] WIN_LO = 8'hFB;
  localparam logic [7:0] WIN_HI = 8'hFD;
  localparam logic [5:0] CMD_PW = 6'h2C;
  localparam logic [5:0] CMD_PW_MASK = 6'h3D;
  localparam logic [1:0] ADDR_KIND = 2'h0;
  localparam logic [1:0] REQ_CNT = 2'h1;
  localparam logic [1:0] RSP_CNT = 2'h0;
  localparam int RSPFLAG_BIT = 2;
  localparam int CC_LSB = 3;
  localparam int TAG_LSB = 3;
  localparam int SIZE_BIT = 3;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TAGSZ = 8'h04;
  localparam logic [7:0] OFS_VALO = 8'h08;
  localparam logic [7:0] OFS_VAHI = 8'h0C;
  localparam logic [7:0] OFS_TGT = 8'h10;
  localparam logic [7:0] OFS_OWN = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_SEEN = 8'h1C;
  localparam logic [7:0] OFS_REGION = 8'h20;
  localparam int CTRL_GO = 0;
  localparam int CTRL_PASS = 1;
  localparam int TAGSZ_SIZE = 8;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // 000b stands for eight
  function automatic logic [2:0] cc_encode(input logic [3:0] n);
    return (n == 4'h8) ? 3'h0 : n[2:0]; // R8
  endfunction : cc_encode

  function automatic logic [3:0] cc_decode(input logic [2:0] c);
    return (c == 3'h0) ? 4'h8 : {1'b0, c}; // R8
  endfunction : cc_decode

  // log2 of region size; all ones above bit 11 saturates at 64
  function automatic logic [6:0] region_shift(input logic sz, input logic [51:0] va);
    logic [6:0] sh;
    sh = 7'h40;
    for (int i = 51; i >= 0; i--) begin
      if (!va[i]) begin
        sh = 7'(PAGE_SHIFT + 1 + i); // R9
      end
    end
    return sz ? sh : 7'(PAGE_SHIFT); // R9
  endfunction : region_shift

  // control bit-times shared by request and response
  function automatic logic [7:0] hdr_byte(input logic [4:0] idx, input logic [15:0] src,
      input logic [4:0] unit, input logic [15:0] tgt, input logic pass, input logic rsp,
      input logic [2:0] cc);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      5'h00: b = PFX_B0; // R3
      5'h01: b = src[7:0];
      5'h02: b = src[15:8];
      5'h03: b = {6'h00, ADDR_KIND}; // R3
      5'h04: b = {2'h0, CMD_PW}; // R3
      5'h05: b = {pass, 2'h0, unit};
      5'h06: b = {rsp ? RSP_CNT : REQ_CNT, 6'h00}; // R4
      5'h07: b = {2'h0, cc, rsp, 2'h0}; // R2
      5'h08: b = tgt[7:0];
      5'h09: b = tgt[15:8];
      5'h0A: b = WIN_LO; // R3
      5'h0B: b = WIN_HI; // R3
      default: b = 8'h00;
    endcase
    return b;
  endfunction : hdr_byte

  // fixed fields a receiver checks, plus reserved bits 5 and 3 of bit-time 6 and bits 1:0 of bit-time 7
  function automatic logic hdr_ok(input logic [4:0] idx, input logic [7:0] b, input logic rsp);
    logic ok;
    ok = 1'b1;
    case (idx)
      5'h00: ok = (b == PFX_B0);
      5'h03: ok = (b[1:0] == ADDR_KIND);
      5'h04: ok = ((b[5:0] & CMD_PW_MASK) == CMD_PW);
      5'h05: ok = !(rsp && b[7]); // R5
      5'h06: ok = (b[7:6] == (rsp ? RSP_CNT : REQ_CNT)) && !b[5] && !b[3];
      5'h07: ok = (b[RSPFLAG_BIT] == rsp) && (b[1:0] == 2'h0); // R2
      5'h0A: ok = (b == WIN_LO);
      5'h0B: ok = (b == WIN_HI);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction : hdr_ok

endpackage : tip_pkg

// >>> logic/tip_link_if.sv
// link between translation agent and caching device, one byte per bit-time
`timescale 1ns/1ps
`default_nettype none
interface tip_link_if;
  logic req_valid;
  logic req_ctl;
  logic [7:0] req_data;
  logic rsp_valid;
  logic rsp_ctl;
  logic [7:0] rsp_data;
  logic rsp_isoc;

  modport dev_end (
    input req_valid,
    input req_ctl,
    input req_data,
    output rsp_valid,
    output rsp_ctl,
    output rsp_data,
    output rsp_isoc
  );

  modport host_end (
    output req_valid,
    output req_ctl,
    output req_data,
    input rsp_valid,
    input rsp_ctl,
    input rsp_data,
    input rsp_isoc
  );
endinterface : tip_link_if
`default_nettype wire

// >>> logic/tip_device_end.sv
// caching device end: decodes invalidation requests, sends tag-mask responses
`timescale 1ns/1ps
`default_nettype none
module tip_device_end import tip_pkg::*; #(
  parameter int MAX_CHAN = MAX_RESP
) (
  input wire logic CLK,
  input wire logic RSTN,
  tip_link_if.dev_end LINK,
  input wire logic [15:0] OWN_BDF,
  input wire logic [4:0] OWN_UNIT,
  input wire logic [3:0] CHAN_COUNT,
  output logic INV_VALID,
  output logic [4:0] INV_TAG,
  output logic INV_SIZE,
  output logic [51:0] INV_VADDR,
  output logic [6:0] INV_SHIFT,
  output logic [15:0] INV_REQ_BDF,
  output logic BAD_PKT,
  input wire logic ACK_VALID,
  input wire logic [31:0] ACK_MASK,
  output logic ACK_READY
);

  if (MAX_CHAN < 1 || MAX_CHAN > MAX_RESP) begin : g_chk
    $error("MAX_CHAN out of range");
  end

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tip_tx_type;

  logic [4:0] rx_idx_r, rx_idx_nxt;
  logic rx_ok_r, rx_ok_nxt;
  logic [15:0] src_r, src_nxt;
  logic [4:0] tag_r, tag_nxt;
  logic size_r, size_nxt;
  logic [51:0] va_r, va_nxt;
  logic inv_valid_r, inv_valid_nxt;
  logic bad_r, bad_nxt;
  logic [4:0] inv_tag_r, inv_tag_nxt;
  logic inv_size_r, inv_size_nxt;
  logic [51:0] inv_va_r, inv_va_nxt;
  logic [6:0] inv_sh_r, inv_sh_nxt;
  logic [15:0] inv_bdf_r, inv_bdf_nxt;

  always_comb begin
    int k;
    k = int'(rx_idx_r);
    rx_idx_nxt = rx_idx_r;
    rx_ok_nxt = rx_ok_r;
    src_nxt = src_r;
    tag_nxt = tag_r;
    size_nxt = size_r;
    va_nxt = va_r;
    inv_valid_nxt = 1'b0;
    bad_nxt = 1'b0;
    inv_tag_nxt = inv_tag_r;
    inv_size_nxt = inv_size_r;
    inv_va_nxt = inv_va_r;
    inv_sh_nxt = inv_sh_r;
    inv_bdf_nxt = inv_bdf_r;
    // a packet only starts on a control bit-time
    if (LINK.req_valid && (rx_idx_r != 5'h00 || LINK.req_ctl)) begin
      rx_ok_nxt = ((rx_idx_r == 5'h00) | rx_ok_r) & (LINK.req_ctl == (k < CTL_BEATS))
                  & hdr_ok(rx_idx_r, LINK.req_data, 1'b0); // R1
      case (rx_idx_r)
        5'h01: src_nxt[7:0] = LINK.req_data;
        5'h02: src_nxt[15:8] = LINK.req_data;
        5'h0C: tag_nxt = LINK.req_data[7:TAG_LSB]; // R4
        5'h0D: begin
          va_nxt[3:0] = LINK.req_data[7:4]; // R4
          size_nxt = LINK.req_data[SIZE_BIT];
        end
        default: begin
          if (k >= 14) begin
            va_nxt[8 * (k - 14) + 4 +: 8] = LINK.req_data; // R4
          end
        end
      endcase
      if (k == REQ_BEATS - 1) begin
        rx_idx_nxt = 5'h00;
        if (rx_ok_nxt) begin
          inv_valid_nxt = 1'b1; // R1
          inv_tag_nxt = tag_nxt;
          inv_size_nxt = size_nxt;
          inv_va_nxt = va_nxt;
          inv_sh_nxt = region_shift(size_nxt, va_nxt); // R9
          inv_bdf_nxt = src_nxt;
        end else begin
          bad_nxt = 1'b1;
        end
      end else begin
        rx_idx_nxt = rx_idx_r + 5'h01;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rx_idx_r <= 5'h00;
      rx_ok_r <= 1'b0;
      src_r <= 16'h0000;
      tag_r <= 5'h00;
      size_r <= 1'b0;
      va_r <= 52'h0;
      inv_valid_r <= 1'b0;
      bad_r <= 1'b0;
      inv_tag_r <= 5'h00;
      inv_size_r <= 1'b0;
      inv_va_r <= 52'h0;
      inv_sh_r <= 7'h00;
      inv_bdf_r <= 16'h0000;
    end else begin
      rx_idx_r <= rx_idx_nxt;
      rx_ok_r <= rx_ok_nxt;
      src_r <= src_nxt;
      tag_r <= tag_nxt;
      size_r <= size_nxt;
      va_r <= va_nxt;
      inv_valid_r <= inv_valid_nxt;
      bad_r <= bad_nxt;
      inv_tag_r <= inv_tag_nxt;
      inv_size_r <= inv_size_nxt;
      inv_va_r <= inv_va_nxt;
      inv_sh_r <= inv_sh_nxt;
      inv_bdf_r <= inv_bdf_nxt;
    end
  end

  tip_tx_type tx_r, tx_nxt;
  logic [3:0] beat_r, beat_nxt;
  logic [3:0] resp_r, resp_nxt;
  logic [3:0] total_r, total_nxt;
  logic [31:0] mask_r, mask_nxt;
  logic [15:0] tgt_r, tgt_nxt;
  logic ack_rdy_r, ack_rdy_nxt;
  logic rv_r, rv_nxt;
  logic rc_r, rc_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic ri_r, ri_nxt;

  always_comb begin
    tx_nxt = tx_r;
    beat_nxt = beat_r;
    resp_nxt = resp_r;
    total_nxt = total_r;
    mask_nxt = mask_r;
    tgt_nxt = inv_valid_r ? inv_bdf_r : tgt_r;
    ack_rdy_nxt = 1'b0;
    rv_nxt = 1'b0;
    rc_nxt = 1'b0;
    rd_nxt = 8'h00;
    ri_nxt = 1'b0;
    case (tx_r)
      TX_IDLE: begin
        ack_rdy_nxt = 1'b1;
        if (ACK_VALID && ack_rdy_r) begin
          ack_rdy_nxt = 1'b0;
          mask_nxt = ACK_MASK; // R6
          // zero or oversize counts are clamped rather than refused
          if (CHAN_COUNT == 4'h0) begin
            total_nxt = 4'h1;
          end else if (CHAN_COUNT > 4'(MAX_CHAN)) begin
            total_nxt = 4'(MAX_CHAN);
          end else begin
            total_nxt = CHAN_COUNT;
          end
          resp_nxt = 4'h0;
          beat_nxt = 4'h0;
          tx_nxt = TX_SEND;
        end
      end
      TX_SEND: begin
        rv_nxt = 1'b1;
        rc_nxt = (int'(beat_r) < CTL_BEATS);
        ri_nxt = resp_r[0]; // R7
        if (int'(beat_r) < CTL_BEATS) begin
          rd_nxt = hdr_byte({1'b0, beat_r}, OWN_BDF, OWN_UNIT, tgt_r, 1'b0, 1'b1,
                            cc_encode(total_r)); // R5
        end else begin
          rd_nxt = mask_r[8 * (int'(beat_r) - CTL_BEATS) +: 8]; // R6
        end
        if (int'(beat_r) == RSP_BEATS - 1) begin
          beat_nxt = 4'h0;
          if (resp_r == total_r - 4'h1) begin
            tx_nxt = TX_IDLE;
          end else begin
            resp_nxt = resp_r + 4'h1; // R7
          end
        end else begin
          beat_nxt = beat_r + 4'h1;
        end
      end
      default: tx_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      tx_r <= TX_IDLE;
      beat_r <= 4'h0;
      resp_r <= 4'h0;
      total_r <= 4'h1;
      mask_r <= 32'h0000_0000;
      tgt_r <= 16'h0000;
      ack_rdy_r <= 1'b0;
      rv_r <= 1'b0;
      rc_r <= 1'b0;
      rd_r <= 8'h00;
      ri_r <= 1'b0;
    end else begin
      tx_r <= tx_nxt;
      beat_r <= beat_nxt;
      resp_r <= resp_nxt;
      total_r <= total_nxt;
      mask_r <= mask_nxt;
      tgt_r <= tgt_nxt;
      ack_rdy_r <= ack_rdy_nxt;
      rv_r <= rv_nxt;
      rc_r <= rc_nxt;
      rd_r <= rd_nxt;
      ri_r <= ri_nxt;
    end
  end

  assign LINK.rsp_valid = rv_r;
  assign LINK.rsp_ctl = rc_r;
  assign LINK.rsp_data = rd_r;
  assign LINK.rsp_isoc = ri_r;
  assign INV_VALID = inv_valid_r;
  assign INV_TAG = inv_tag_r;
  assign INV_SIZE = inv_size_r;
  assign INV_VADDR = inv_va_r;
  assign INV_SHIFT = inv_sh_r;
  assign INV_REQ_BDF = inv_bdf_r;
  assign BAD_PKT = bad_r;
  assign ACK_READY = ack_rdy_r;

endmodule : tip_device_end
`default_nettype wire

// >>> verif/tip_checker.sv
// link checker for invalidation request and response framing
`timescale 1ns/1ps
`default_nettype none
module tip_checker import tip_pkg::*; (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic req_valid,
  input wire logic req_ctl,
  input wire logic [7:0] req_data,
  input wire logic rsp_valid,
  input wire logic rsp_ctl,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_isoc
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_qc; req_valid && req_ctl; endsequence
  sequence s_rc; rsp_valid && rsp_ctl; endsequence
  sequence s_next; rsp_valid && rsp_ctl && $past(rsp_valid) && !$past(rsp_ctl); endsequence
  property p_req_frame;
    $rose(req_valid) |-> s_qc [*8] ##1 s_qc [*4] ##1 (req_valid && !req_ctl) [*8] ##1 !req_valid;
  endproperty
  property p_req_hdr;
    $rose(req_valid) |-> req_data == PFX_B0 ##3 req_data[1:0] == ADDR_KIND
      ##1 req_data[5:0] == CMD_PW ##6 req_data == WIN_LO ##1 req_data == WIN_HI;
  endproperty
  property p_req_kind;
    $rose(req_valid) |-> ##6 req_data[7:6] == REQ_CNT ##1 !req_data[RSPFLAG_BIT];
  endproperty
  property p_rsp_frame;
    $rose(rsp_valid) |-> s_rc [*8] ##1 s_rc [*4] ##1 (rsp_valid && !rsp_ctl) [*4];
  endproperty
  property p_rsp_hdr;
    $rose(rsp_valid) |-> rsp_data == PFX_B0 ##5 !rsp_data[7] ##1 rsp_data[7:6] == RSP_CNT
      ##1 rsp_data[RSPFLAG_BIT] ##3 rsp_data == WIN_LO ##1 rsp_data == WIN_HI;
  endproperty
  property p_isoc0;
    $rose(rsp_valid) |-> !rsp_isoc;
  endproperty
  property p_isoc_alt;
    s_next |-> rsp_isoc != $past(rsp_isoc);
  endproperty
  // channel may only change where a new response begins
  property p_isoc_hold;
    (rsp_valid && $past(rsp_valid) && !(rsp_ctl && !$past(rsp_ctl))) |-> $stable(rsp_isoc);
  endproperty
  a_req_frame: assert property (p_req_frame) else $error("request framing wrong");
  a_req_hdr: assert property (p_req_hdr) else $error("request header wrong");
  a_req_kind: assert property (p_req_kind) else $error("request count or flag wrong");
  a_rsp_frame: assert property (p_rsp_frame) else $error("response framing wrong");
  a_rsp_hdr: assert property (p_rsp_hdr) else $error("response header wrong");
  a_isoc0: assert property (p_isoc0) else $error("first response not normal");
  a_isoc_alt: assert property (p_isoc_alt) else $error("channel not alternating");
  a_isoc_hold: assert property (p_isoc_hold) else $error("channel moved mid response");
endmodule : tip_checker
`default_nettype wire

// >>> verif/translation_invalidation_packets_bench.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module translation_invalidation_packets_bench import tip_pkg::*; ;
  logic CLK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, ACK_VALID = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, ACK_MASK = 32'h0, PRDATA, rd;
  logic [3:0] CHAN_COUNT = 4'h1;
  logic PREADY, PSLVERR, INV_BUSY, INV_DONE, ACK_READY, INV_VALID, INV_SIZE, er, sz, BAD_PKT;
  logic [4:0] INV_TAG, tag;
  logic [51:0] INV_VADDR;
  logic [6:0] INV_SHIFT;
  logic [15:0] INV_REQ_BDF;
  logic [7:0] rb [16];
  int errors = 0, num_checks = 0, cyc = 0, beat = 0, nresp = 0, n = 0, nbad = 0;
  tip_link_if tip_link_if_i ();
  tip_host_end tip_host_end_i (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .LINK(tip_link_if_i), .INV_BUSY(INV_BUSY), .INV_DONE(INV_DONE));
  tip_device_end #(.MAX_CHAN(8)) tip_device_end_i (.CLK(CLK), .RSTN(RSTN),
    .LINK(tip_link_if_i), .OWN_BDF(16'h5678), .OWN_UNIT(5'h05), .CHAN_COUNT(CHAN_COUNT),
    .INV_VALID(INV_VALID), .INV_TAG(INV_TAG), .INV_SIZE(INV_SIZE), .INV_VADDR(INV_VADDR),
    .INV_SHIFT(INV_SHIFT), .INV_REQ_BDF(INV_REQ_BDF), .BAD_PKT(BAD_PKT), .ACK_VALID(ACK_VALID),
    .ACK_MASK(ACK_MASK), .ACK_READY(ACK_READY));
  tip_checker tip_checker_i (.CLK(CLK), .RSTN(RSTN), .req_valid(tip_link_if_i.req_valid),
    .req_ctl(tip_link_if_i.req_ctl), .req_data(tip_link_if_i.req_data),
    .rsp_valid(tip_link_if_i.rsp_valid), .rsp_ctl(tip_link_if_i.rsp_ctl),
    .rsp_data(tip_link_if_i.rsp_data), .rsp_isoc(tip_link_if_i.rsp_isoc));
  initial begin
    forever #5 CLK = ~CLK;
  end
  task automatic conclude;
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  // returns once the device is idle again, so responses are complete
  task automatic ack(input logic [31:0] m);
    @(posedge CLK);
    ACK_VALID <= 1'b1;
    ACK_MASK <= m;
    do @(posedge CLK); while (ACK_READY !== 1'b1);
    ACK_VALID <= 1'b0;
    do @(posedge CLK); while (ACK_READY !== 1'b1);
  endtask : ack
  always @(posedge CLK) begin
    cyc++;
    if (RSTN === 1'b1 && BAD_PKT !== 1'b0) nbad++;
    if (tip_link_if_i.rsp_valid === 1'b1) begin
      rb[beat] = tip_link_if_i.rsp_data;
      beat = (beat + 1) % 16;
      if (beat == 0) nresp++;
    end
    if (cyc > 5000) begin
      errors++;
      conclude;
    end
  end
  initial begin
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd, REG_RST);
    apb(1'b0, 8'h24, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, OFS_OWN, 32'h0005_1234);
    apb(1'b1, OFS_TGT, 32'h0000_ABCD);
    apb(1'b1, OFS_VALO, 32'h1234_7000);
    apb(1'b1, OFS_VAHI, 32'h89AB_CDEF);
    for (int k = 0; k < 3; k++) begin
      n = (k == 0) ? 1 : (k == 1) ? 2 : 8;
      sz = (k != 1);
      tag = 5'h07 + 5'(k * 9);
      CHAN_COUNT <= 4'(n);
      apb(1'b1, OFS_TAGSZ, {23'h0, sz, 3'h0, tag});
      // last pass also sets may-overtake, carried by the request only
      apb(1'b1, OFS_CTRL, (k == 2) ? 32'h3 : 32'h1);
      do @(posedge CLK); while (INV_VALID !== 1'b1);
      chk(INV_TAG, tag);
      chk(INV_SIZE, sz);
      chk(INV_VADDR, 52'h8_9ABC_DEF1_2347);
      chk(INV_SHIFT, sz ? 7'h10 : 7'h0C);
      chk(INV_REQ_BDF, 16'h1234);
      if (k == 0) begin
        ack(~(32'h1 << tag));
        chk(INV_BUSY, 1'b1);
      end
      nresp = 0;
      ack(32'h1 << tag);
      do @(posedge CLK); while (INV_DONE !== 1'b1);
      chk(nresp, n);
      chk(rb[7][5:3], (n == 8) ? 3'h0 : 3'(n));
      chk({rb[9], rb[8]}, 16'h1234);
      chk({rb[2], rb[1]}, 16'h5678);
      chk(rb[5][4:0], 5'h05);
      chk({rb[15], rb[14], rb[13], rb[12]}, 32'h1 << tag);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd, (32'(n) << 12) | (32'(n) << 8) | 32'h2);
      apb(1'b0, OFS_REGION, 32'h0);
      chk(rd, sz ? 32'h10 : 32'h0C);
      apb(1'b0, OFS_SEEN, 32'h0);
      chk(rd, 32'h1 << tag);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, (k == 2) ? 32'h2 : 32'h0);
    end
    chk(nbad, 0);
    conclude;
  end
endmodule : translation_invalidation_packets_bench
`default_nettype wire
